//--- core/lssmc_top.v
// Low-side supervisor and monitor mode control with settle delays and wake timing
// What this block and its software do
// R1: In active mode and light sleep the supervisor is off when disabled, else normal or full per fast_perf.
// R2: In deep sleep the supervisor is off or keeps its active state by mode bit under manual control,
//     and under automatic control is off except normal when enable, mode and fast_perf are all set.
// R3: The monitor is off when disabled, follows fast_perf when awake, keeps that in deep sleep manually, and automatically is off or normal when fast_perf is set.
// R4: Wake-up from deep sleep uses the fast time when a unit is disabled or full-performance and the slow time when both are enabled in normal mode.
// R5: In full-performance mode the settle delay after a configuration change is about 2 us.
// R6: In normal mode the settle delay is about 150 us so a raised core level can settle.
// R7: If the core level has not reached a newly raised level when the settle delay ends, a device reset is raised.
// R8: Software raising the core level first puts the supervisor in normal mode with fast_perf cleared.
// R9: Software waits for both settle delay flags to read zero after a control write before deep sleep entry.
// R10: A deep-sleep hang caused by a wake interrupt within 1 us of entry is cleared only by external reset, power cycle or soft reset.
// R11: Software may keep the sub-clock request set and must halt its dependent peripherals before the deepest sleeps.
// R12: After wake-up software waits 32, 48, 80 or 100 cycles per core level before re-enabling a disturbed peripheral.
// R13: Software may source the sub main clock from the second crystal oscillator instead.
`timescale 1ns/1ps
`include "lssmc_map.vh"
module lssmc_top #(
  parameter CW          = 16,
  parameter FAST_CYCLES = `LSSMC_T_FAST_SETTLE_US * `LSSMC_CLK_MHZ,
  parameter SLOW_CYCLES = `LSSMC_T_SLOW_SETTLE_US * `LSSMC_CLK_MHZ,
  parameter WIN_CYCLES  = `LSSMC_T_ENTRY_WIN_US * `LSSMC_CLK_MHZ
) (
  // Clock and reset
  input  wire                     core_clk,
  input  wire                     sys_rst,
  // Avalon-MM slave
  input  wire [`LSSMC_ADDR_W-1:0] avs_address,
  input  wire                     avs_read,
  input  wire                     avs_write,
  input  wire [31:0]              avs_writedata,
  output reg  [31:0]              avs_readdata,
  output wire                     avs_waitrequest,
  // Power mode and events
  input  wire [1:0]               power_mode,
  input  wire                     wake_irq,
  input  wire                     soft_power_up_clear,
  input  wire                     core_level_reached,
  // Comparator control
  output reg  [1:0]               low_supply_supervisor,
  output reg  [1:0]               low_supply_monitor,
  output wire                     wake_fast,
  output reg                      wake_done,
  output reg                      device_reset,
  output wire                     deep_sleep_hang,
  output wire                     irq
);

  // ============================================================
  // Declarations
  localparam [CW-1:0] FAST_LOAD = FAST_CYCLES[CW-1:0];
  localparam [CW-1:0] SLOW_LOAD = SLOW_CYCLES[CW-1:0];
  localparam [CW-1:0] WIN_LOAD  = WIN_CYCLES[CW-1:0];

  reg                      ack_reg;
  reg [`LSSMC_LC_W-1:0]    low_supervisor_control_reg;
  reg [`LSSMC_HC_W-1:0]    high_supervisor_control_reg;
  reg [`LSSMC_IRQ_W-1:0]   irq_status_reg;
  reg [`LSSMC_IRQ_W-1:0]   irq_mask_reg;
  reg [`LSSMC_LVL_W-1:0]   core_level_reg;
  reg                      raise_pend_reg;
  reg                      lvl_meta_reg;
  reg                      lvl_sync_reg;
  reg                      deep_prev_reg;
  reg [CW-1:0]             win_cnt_reg;
  reg                      hang_reg;
  reg                      wake_busy_prev_reg;
  reg [`LSSMC_IRQ_W-1:0]   irq_set;
  reg [1:0]                sup_awake;
  reg [1:0]                mon_awake;
  reg [31:0]               rd_next;

  wire                     bus_req;
  wire                     wr_take;
  wire                     wr_low;
  wire                     wr_high;
  wire                     wr_lvl;
  wire                     low_busy;
  wire                     low_done;
  wire                     high_busy;
  wire                     high_done;
  wire                     wake_busy;
  wire                     wake_start;
  wire                     deep;
  wire                     deep_entry;
  wire                     sup_en;
  wire                     sup_md;
  wire                     sup_fp;
  wire                     mon_en;
  wire                     mon_fp;
  wire                     auto_ce;
  wire                     new_fp;
  wire                     hang_set;

  // ============================================================
  // Avalon-MM handshake
  // Each request waits one cycle; the transfer completes at the edge with waitrequest low
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign wr_take         = avs_write & ack_reg;
  assign wr_low          = wr_take & (avs_address == `LSSMC_OFS_LOW_CTRL);
  assign wr_high         = wr_take & (avs_address == `LSSMC_OFS_HIGH_CTRL);
  assign wr_lvl          = wr_take & (avs_address == `LSSMC_OFS_CORE_LEVEL);

  // Acknowledge pulses high for one cycle per request
  always @(posedge core_clk)
  begin
    if (sys_rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  // ============================================================
  // Control field decode
  assign sup_en  = low_supervisor_control_reg[`LSSMC_LC_SUP_EN];
  assign sup_md  = low_supervisor_control_reg[`LSSMC_LC_SUP_MD];
  assign sup_fp  = low_supervisor_control_reg[`LSSMC_LC_SUP_FP];
  assign mon_en  = low_supervisor_control_reg[`LSSMC_LC_MON_EN];
  assign mon_fp  = low_supervisor_control_reg[`LSSMC_LC_MON_FP];
  assign auto_ce = low_supervisor_control_reg[`LSSMC_LC_AUTO];
  assign new_fp  = avs_writedata[`LSSMC_LC_SUP_FP];

  // ============================================================
  // Control registers
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      low_supervisor_control_reg  <= `LSSMC_LC_RST;
      high_supervisor_control_reg <= `LSSMC_HC_RST;
      irq_mask_reg                <= `LSSMC_IRQ_RST;
      core_level_reg              <= `LSSMC_LVL_RST;
    end
    else if (wr_take)
    begin
      if (wr_low)
        low_supervisor_control_reg <= avs_writedata[`LSSMC_LC_W-1:0];
      if (wr_high)
        high_supervisor_control_reg <= avs_writedata[`LSSMC_HC_W-1:0];
      if (avs_address == `LSSMC_OFS_IRQ_MASK)
        irq_mask_reg <= avs_writedata[`LSSMC_IRQ_W-1:0];
      if (wr_lvl)
        core_level_reg <= avs_writedata[`LSSMC_LVL_W-1:0];
    end
  end

  // ============================================================
  // Settle delay timers
  // Low delay length follows the fast_perf bit in force after the change
  lssmc_settle_timer #(
    .CW (CW)
  ) u_low_dly (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (wr_low | wr_lvl),
    .load     ((wr_low ? new_fp : sup_fp) ? FAST_LOAD : SLOW_LOAD), // R5 R6
    .busy     (low_busy),
    .done     (low_done)
  );

  // High side control change always gets the long delay
  lssmc_settle_timer #(
    .CW (CW)
  ) u_high_dly (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (wr_high),
    .load     (SLOW_LOAD),
    .busy     (high_busy),
    .done     (high_done)
  );

  // ============================================================
  // Core level raise check
  // Level reached arrives from the analog side and is synchronised first
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      lvl_meta_reg <= 1'b0;
      lvl_sync_reg <= 1'b0;
    end
    else
    begin
      lvl_meta_reg <= core_level_reached;
      lvl_sync_reg <= lvl_meta_reg;
    end
  end

  // A raise is armed by the write and judged when the settle delay ends
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      raise_pend_reg <= 1'b0;
      device_reset   <= 1'b0;
    end
    else
    begin
      device_reset <= low_done & raise_pend_reg & ~lvl_sync_reg; // R7
      if (wr_lvl & (avs_writedata[`LSSMC_LVL_W-1:0] > core_level_reg))
        raise_pend_reg <= 1'b1;
      else if (low_done)
        raise_pend_reg <= 1'b0;
    end
  end

  // ============================================================
  // Comparator state decode
  assign deep = (power_mode == `LSSMC_PM_DEEP);

  // Awake states and sleep states of supervisor and monitor
  always @*
  begin
    sup_awake = sup_en ? (sup_fp ? `LSSMC_CMP_FULL : `LSSMC_CMP_NORM) : `LSSMC_CMP_OFF; // R1
    mon_awake = mon_en ? (mon_fp ? `LSSMC_CMP_FULL : `LSSMC_CMP_NORM) : `LSSMC_CMP_OFF; // R3
    low_supply_supervisor = sup_awake;
    low_supply_monitor    = mon_awake;
    if (deep)
    begin
      if (!auto_ce)
      begin
        low_supply_supervisor = sup_md ? sup_awake : `LSSMC_CMP_OFF; // R2
        low_supply_monitor    = mon_awake; // R3
      end
      else
      begin
        low_supply_supervisor = (sup_en & sup_md & sup_fp) ? `LSSMC_CMP_NORM
                                                           : `LSSMC_CMP_OFF; // R2
        low_supply_monitor    = (mon_en & mon_fp) ? `LSSMC_CMP_NORM
                                                  : `LSSMC_CMP_OFF; // R3
      end
    end
  end

  // Fast wake when either unit is off or in full performance
  assign wake_fast = ~sup_en | sup_fp | ~mon_en | mon_fp; // R4

  // ============================================================
  // Deep sleep entry window and hang
  assign deep_entry = deep & ~deep_prev_reg;
  assign hang_set   = deep & wake_irq & (win_cnt_reg != {CW{1'b0}}) &
                      (low_busy | high_busy | wake_fast);

  // Entry window counts down from each deep sleep entry
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      deep_prev_reg <= 1'b0;
      win_cnt_reg   <= {CW{1'b0}};
    end
    else
    begin
      deep_prev_reg <= deep;
      if (deep_entry)
        win_cnt_reg <= WIN_LOAD;
      else if (!deep)
        win_cnt_reg <= {CW{1'b0}};
      else if (win_cnt_reg != {CW{1'b0}})
        win_cnt_reg <= win_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // Hang holds until a reset of either kind
  always @(posedge core_clk)
  begin
    if (sys_rst | soft_power_up_clear) // R10
      hang_reg <= 1'b0;
    else if (hang_set)
      hang_reg <= 1'b1;
  end

  assign deep_sleep_hang = hang_reg;

  // ============================================================
  // Wake-up timing
  // A hung device ignores wake requests
  assign wake_start = deep & wake_irq & ~hang_set & ~hang_reg & ~wake_busy;

  lssmc_settle_timer #(
    .CW (CW)
  ) u_wake (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (wake_start),
    .load     (wake_fast ? FAST_LOAD : SLOW_LOAD), // R4
    .busy     (wake_busy),
    .done     ()
  );

  // Wake done pulses at the end of the wake time
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      wake_busy_prev_reg <= 1'b0;
      wake_done          <= 1'b0;
    end
    else
    begin
      wake_busy_prev_reg <= wake_busy;
      wake_done          <= wake_busy_prev_reg & ~wake_busy & ~hang_reg; // R10
    end
  end

  // ============================================================
  // Interrupt status, set wins over write-one clear
  always @*
  begin
    irq_set = `LSSMC_IRQ_RST;
    irq_set[`LSSMC_IRQ_LOW_DONE]  = low_done;
    irq_set[`LSSMC_IRQ_HIGH_DONE] = high_done;
    irq_set[`LSSMC_IRQ_SUP_RESET] = low_done & raise_pend_reg & ~lvl_sync_reg;
    irq_set[`LSSMC_IRQ_HANG]      = hang_set & ~hang_reg;
  end

  always @(posedge core_clk)
  begin
    if (sys_rst)
      irq_status_reg <= `LSSMC_IRQ_RST;
    else if (wr_take & (avs_address == `LSSMC_OFS_IRQ_STATUS))
      irq_status_reg <= (irq_status_reg & ~avs_writedata[`LSSMC_IRQ_W-1:0]) | irq_set;
    else
      irq_status_reg <= irq_status_reg | irq_set;
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ============================================================
  // Read data mux
  // Unmapped addresses read as zero
  always @*
  begin
    rd_next = 32'h00000000;
    case (avs_address)
      `LSSMC_OFS_LOW_CTRL:
        rd_next[`LSSMC_LC_W-1:0] = low_supervisor_control_reg;
      `LSSMC_OFS_HIGH_CTRL:
        rd_next[`LSSMC_HC_W-1:0] = high_supervisor_control_reg;
      `LSSMC_OFS_POWER_FLAG:
      begin
        rd_next[`LSSMC_PF_LOW_DLY]  = low_busy; // R9
        rd_next[`LSSMC_PF_HIGH_DLY] = high_busy; // R9
      end
      `LSSMC_OFS_IRQ_STATUS:
        rd_next[`LSSMC_IRQ_W-1:0] = irq_status_reg;
      `LSSMC_OFS_IRQ_MASK:
        rd_next[`LSSMC_IRQ_W-1:0] = irq_mask_reg;
      `LSSMC_OFS_STATE:
        rd_next[5:0] = {hang_reg, wake_fast, low_supply_monitor, low_supply_supervisor};
      `LSSMC_OFS_CORE_LEVEL:
        rd_next[`LSSMC_LVL_W-1:0] = core_level_reg;
      default:
        rd_next = 32'h00000000;
    endcase
  end

  // Read data is captured on the waiting edge so it stands when waitrequest drops
  always @(posedge core_clk)
  begin
    if (sys_rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read & ~ack_reg)
      avs_readdata <= rd_next;
  end

endmodule

//--- core/lssmc_map.vh
// Register map, field positions and timing constants of the low-side supervisor control
`ifndef LSSMC_MAP_VH
`define LSSMC_MAP_VH

// ============================================================
// Clock and timing
`define LSSMC_CLK_MHZ          200
`define LSSMC_T_FAST_SETTLE_US 2
`define LSSMC_T_SLOW_SETTLE_US 150
`define LSSMC_T_ENTRY_WIN_US   1

// ============================================================
// Register byte offsets
`define LSSMC_ADDR_W           5
`define LSSMC_OFS_LOW_CTRL     5'h00
`define LSSMC_OFS_HIGH_CTRL    5'h04
`define LSSMC_OFS_POWER_FLAG   5'h08
`define LSSMC_OFS_IRQ_STATUS   5'h0C
`define LSSMC_OFS_IRQ_MASK     5'h10
`define LSSMC_OFS_STATE        5'h14
`define LSSMC_OFS_CORE_LEVEL   5'h18

// ============================================================
// Low control fields, high control width and reset
`define LSSMC_LC_SUP_EN        0
`define LSSMC_LC_SUP_MD        1
`define LSSMC_LC_SUP_FP        2
`define LSSMC_LC_MON_EN        3
`define LSSMC_LC_MON_FP        4
`define LSSMC_LC_AUTO          5
`define LSSMC_LC_W             6
`define LSSMC_LC_RST           6'h00
`define LSSMC_HC_W             8
`define LSSMC_HC_RST           8'h00

// ============================================================
// Power flag, interrupt and core level fields
`define LSSMC_PF_LOW_DLY       0
`define LSSMC_PF_HIGH_DLY      1
`define LSSMC_IRQ_W            4
`define LSSMC_IRQ_LOW_DONE     0
`define LSSMC_IRQ_HIGH_DONE    1
`define LSSMC_IRQ_SUP_RESET    2
`define LSSMC_IRQ_HANG         3
`define LSSMC_IRQ_RST          4'h0
`define LSSMC_LVL_W            2
`define LSSMC_LVL_RST          2'h0

// ============================================================
// Comparator states and power modes
`define LSSMC_CMP_OFF          2'h0
`define LSSMC_CMP_NORM         2'h1
`define LSSMC_CMP_FULL         2'h2
`define LSSMC_PM_ACTIVE        2'h0
`define LSSMC_PM_LIGHT         2'h1
`define LSSMC_PM_DEEP          2'h2

`endif

//--- core/lssmc_settle_timer.v
// Reloadable down-counter that is busy for a loaded number of cycles
`timescale 1ns/1ps
module lssmc_settle_timer #(
  parameter CW = 16
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          sys_rst,
  // Control
  input  wire          start,
  input  wire [CW-1:0] load,
  // Status
  output wire          busy,
  output reg           done
);

  reg [CW-1:0] cnt_reg;

  // ============================================================
  // Counter
  // A restart while busy reloads, so the delay always runs from the last change
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= {CW{1'b0}};
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
        cnt_reg <= load;
      else if (cnt_reg != {CW{1'b0}})
      begin
        cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        if (cnt_reg == {{(CW-1){1'b0}}, 1'b1})
          done <= 1'b1;
      end
    end
  end

  assign busy = (cnt_reg != {CW{1'b0}});

endmodule

//--- tb/lssmc_top_sva.sv
// Port-level assertion checker for the low-side supervisor mode control
`timescale 1ns/1ps
module lssmc_top_sva (
  // Clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // Register bus
  input wire [4:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Power mode and events
  input wire [1:0]  power_mode,
  input wire        wake_irq,
  input wire        soft_power_up_clear,
  input wire        core_level_reached,
  // Comparator control
  input wire [1:0]  low_supply_supervisor,
  input wire [1:0]  low_supply_monitor,
  input wire        wake_fast,
  input wire        wake_done,
  input wire        device_reset,
  input wire        deep_sleep_hang,
  input wire        irq
);
  // ==========
  // Shadow of the low control register, taken from completed bus writes
  reg  [5:0] lc_reg;
  always @(posedge core_clk)
    if (sys_rst)
      lc_reg <= 6'h00;
    else if (avs_write && !avs_waitrequest && avs_address == 5'h00)
      lc_reg <= avs_writedata[5:0];
  // Expected comparator states per power mode
  wire       deep   = power_mode == 2'h2;
  wire [1:0] sup_aw = !lc_reg[0] ? 2'h0 : (lc_reg[2] ? 2'h2 : 2'h1);
  wire [1:0] sup_dp = lc_reg[5] ? {1'h0, &lc_reg[2:0]} : (lc_reg[1] ? sup_aw : 2'h0);
  wire [1:0] mon_aw = !lc_reg[3] ? 2'h0 : (lc_reg[4] ? 2'h2 : 2'h1);
  wire [1:0] mon_dp = lc_reg[5] ? {1'h0, lc_reg[3] & lc_reg[4]} : mon_aw;
  wire       slow   = lc_reg[0] & !lc_reg[2] & lc_reg[3] & !lc_reg[4];
  wire       ctl_wr = avs_write && (avs_address == 5'h0C || avs_address == 5'h10);

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========
  // Properties
  property p_sup_awake; !deep |-> low_supply_supervisor == sup_aw; endproperty
  a_sup_awake: assert property (p_sup_awake) else $error("supervisor state wrong awake");
  property p_sup_deep; deep |-> low_supply_supervisor == sup_dp; endproperty
  a_sup_deep: assert property (p_sup_deep) else $error("supervisor state wrong asleep");
  property p_mon; low_supply_monitor == (deep ? mon_dp : mon_aw); endproperty
  a_mon: assert property (p_mon) else $error("monitor state wrong");
  property p_wake_fast; wake_fast == !slow; endproperty
  a_wake_fast: assert property (p_wake_fast) else $error("wake speed wrong");
  property p_wait_first; (avs_read || avs_write) && !$past(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait_first: assert property (p_wait_first) else $error("bus wait cycle wrong");
  property p_unmapped; avs_read && !avs_waitrequest && avs_address > 5'h18
    |-> avs_readdata == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_pulse; device_reset |=> !device_reset; endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("device reset too long");
  property p_hang_hold; deep_sleep_hang && !soft_power_up_clear |=> deep_sleep_hang; endproperty
  a_hang_hold: assert property (p_hang_hold) else $error("hang cleared early");
  property p_hang_block; deep_sleep_hang |-> !wake_done; endproperty
  a_hang_block: assert property (p_hang_block) else $error("wake while hung");
  property p_irq_hold; irq && !ctl_wr |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
endmodule

bind lssmc_top lssmc_top_sva u_sva (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .power_mode(power_mode), .wake_irq(wake_irq),
  .soft_power_up_clear(soft_power_up_clear), .core_level_reached(core_level_reached),
  .low_supply_supervisor(low_supply_supervisor), .low_supply_monitor(low_supply_monitor),
  .wake_fast(wake_fast), .wake_done(wake_done), .device_reset(device_reset),
  .deep_sleep_hang(deep_sleep_hang), .irq(irq));

//--- tb/lssmc_top_tb.sv
// Self-checking testbench for the low-side supervisor mode control
`timescale 1ns/1ps
module lssmc_top_tb;
  localparam int FAST = 4;
  localparam int SLOW = 20;
  // Design inputs
  logic        core_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [1:0]  power_mode = 2'h0;
  logic        wake_irq = 1'h0;
  logic        soft_power_up_clear = 1'h0;
  logic        core_level_reached = 1'h0;
  // Design outputs
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [1:0]  sup;
  wire  [1:0]  mon;
  wire         wake_fast, wake_done, device_reset, deep_sleep_hang, irq;
  // Bench state
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n, lo;
  logic [31:0] q;

  lssmc_top #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW), .WIN_CYCLES(6)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .power_mode(power_mode), .wake_irq(wake_irq),
    .soft_power_up_clear(soft_power_up_clear), .core_level_reached(core_level_reached),
    .low_supply_supervisor(sup), .low_supply_monitor(mon), .wake_fast(wake_fast),
    .wake_done(wake_done), .device_reset(device_reset), .deep_sleep_hang(deep_sleep_hang),
    .irq(irq));

  // ==========
  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========
  // Tasks
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'h0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? irq === 1'h1 : w == 1 ? device_reset === 1'h1 :
           w == 2 ? deep_sleep_hang === 1'h1 : wake_done === 1'h1;
  endfunction
  // Counts edges until the chosen output is seen high, at most lim + 1
  task automatic wait_for(input int w, input int lim);
    n = 0;
    while (n <= lim && !sig(w))
    begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic wake_pulse();
    wake_irq <= 1'h1;
    @(posedge core_clk);
    wake_irq <= 1'h0;
  endtask
  function automatic logic [1:0] es(input logic [5:0] v, input int p);
    logic [1:0] aw;
    aw = !v[0] ? 2'h0 : v[2] ? 2'h2 : 2'h1;
    if (p != 2)
      return aw;
    if (v[5])
      return {1'h0, &v[2:0]};
    return v[1] ? aw : 2'h0;
  endfunction
  function automatic logic [1:0] em(input logic [5:0] v, input int p);
    logic [1:0] aw;
    aw = !v[3] ? 2'h0 : v[4] ? 2'h2 : 2'h1;
    return (p == 2 && v[5]) ? {1'h0, v[3] & v[4]} : aw;
  endfunction

  // ==========
  // Test sequence
  initial
  begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'h0;
    chk("wake_fast", 32'h1, 32'(wake_fast));
    for (int a = 0; a < 8; a++)
      rdc(5'(a * 4), a == 5 ? 32'h10 : 32'h0, "reset value");
    wr(5'h08, 32'h3);
    rdc(5'h08, 32'h0, "read-only flag");
    // Every control setting in every power mode
    for (int v = 0; v < 64; v++)
    begin
      wr(5'h00, 32'(v));
      for (int p = 0; p < 4; p++)
      begin
        power_mode <= 2'(p);
        @(posedge core_clk);
        chk("supervisor", 32'(es(6'(v), p)), 32'(sup));
        chk("monitor", 32'(em(6'(v), p)), 32'(mon));
        chk("wake_fast", 32'(!(v[0] & !v[2] & v[3] & !v[4])), 32'(wake_fast));
      end
    end
    rdc(5'h00, 32'h3F, "low control");
    // Settle delay lengths, flags and done status
    wr(5'h10, 32'hF);
    repeat (SLOW + 5) @(posedge core_clk);
    wr(5'h0C, 32'hF);
    for (int f = 0; f < 2; f++)
    begin
      wr(5'h00, f ? 32'h05 : 32'h01);
      rdc(5'h08, 32'h1, "low flag busy");
      wait_for(0, 40);
      lo = f ? FAST : SLOW;
      chk("settle length", 32'h1, 32'(n >= lo - 3 && n <= lo + 3));
      rdc(5'h08, 32'h0, "low flag idle");
      rdc(5'h0C, 32'h1, "low done status");
      wr(5'h0C, 32'h1);
      rdc(5'h0C, 32'h0, "status cleared");
    end
    wr(5'h04, 32'hA5);
    rdc(5'h08, 32'h2, "high flag busy");
    wait_for(0, 40);
    chk("high settle", 32'h1, 32'(n <= SLOW + 3));
    rdc(5'h04, 32'hA5, "high control");
    wr(5'h0C, 32'hF);
    // Core level raise with and without the supply keeping up
    for (int c = 0; c < 3; c++)
    begin
      core_level_reached <= (c == 1);
      wr(5'h00, c == 2 ? 32'h05 : 32'h01);
      wr(5'h18, 32'(c + 1));
      wait_for(1, SLOW + 6);
      lo = c == 2 ? FAST : SLOW;
      chk("core raise reset", 32'(c != 1), 32'(n >= lo - 1 && n <= lo + 4));
      repeat (8) @(posedge core_clk);
      rdc(5'h0C, c == 1 ? 32'h1 : 32'h5, "reset status");
      rdc(5'h18, 32'(c + 1), "core level");
      wr(5'h0C, 32'hF);
    end
    // Wake interrupt right after deep sleep entry hangs the device
    wr(5'h00, 32'h00);
    repeat (SLOW + 5) @(posedge core_clk);
    wr(5'h0C, 32'hF);
    power_mode <= 2'h2;
    @(posedge core_clk);
    wake_pulse();
    wait_for(2, 4);
    chk("hang set", 32'h1, 32'(n <= 4));
    rdc(5'h0C, 32'h8, "hang status");
    rdc(5'h14, 32'h30, "state word");
    wake_pulse();
    wait_for(3, SLOW + 8);
    chk("wake blocked", 32'h1, 32'(n > SLOW + 8));
    soft_power_up_clear <= 1'h1;
    @(posedge core_clk);
    soft_power_up_clear <= 1'h0;
    @(posedge core_clk);
    @(posedge core_clk);
    chk("hang cleared", 32'h0, 32'(deep_sleep_hang));
    // Wake time fast with units off, slow with both in normal mode
    for (int w = 0; w < 2; w++)
    begin
      power_mode <= 2'h0;
      wr(5'h00, w ? 32'h09 : 32'h00);
      repeat (SLOW + 5) @(posedge core_clk);
      power_mode <= 2'h2;
      repeat (10) @(posedge core_clk);
      wake_pulse();
      wait_for(3, SLOW + 8);
      lo = w ? SLOW : FAST;
      chk("wake time", 32'h1, 32'(n >= lo - 1 && n <= lo + 4));
      repeat (100) @(posedge core_clk);
    end
    power_mode <= 2'h0;
    // Masking and clearing of the hang interrupt
    wr(5'h10, 32'h0);
    @(posedge core_clk);
    chk("irq masked", 32'h0, 32'(irq));
    wr(5'h10, 32'h8);
    @(posedge core_clk);
    chk("irq raised", 32'h1, 32'(irq));
    wr(5'h0C, 32'h8);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, 32'(irq));
    print_verdict();
  end
endmodule
